// ==== verilog/fwpg_params.svh ====
// timing counts and field constants for the wake and power-up gate
`ifndef FWPG_PARAMS_SVH
`define FWPG_PARAMS_SVH
`define FWPG_CLK_KHZ 50000
`define FWPG_PUW_MS 1
`define FWPG_PUW_CYC (`FWPG_PUW_MS * `FWPG_CLK_KHZ)
`define FWPG_VSL_US 30
`define FWPG_VSL_CYC ((`FWPG_VSL_US * `FWPG_CLK_KHZ + 999) / 1000)
`define FWPG_WAKE_US 30
`define FWPG_WAKE_CYC ((`FWPG_WAKE_US * `FWPG_CLK_KHZ) / 1000)
`define FWPG_CMD_BITS 4'h8
`define FWPG_BITCNT_SAT 4'h9
`endif

// ==== verilog/fwpg_pkg.sv ====
// types shared by the wake and power-up gate
package fwpg_pkg;
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_STANDBY = 4'b0010,
    ST_DEEP = 4'b0100,
    ST_WAKING = 4'b1000
  } fwpg_state_e;
  typedef logic [7:0] fwpg_byte_t;
endpackage

// ==== verilog/fwpg_link.sv ====
// serial-clock side: shifts the command byte and counts clock edges of the frame
`timescale 1ns/100ps
`include "fwpg_params.svh"
module fwpg_link (
  input wire logic serialClk,
  input wire logic chipSelN,
  input wire logic serialInLine,
  output fwpg_pkg::fwpg_byte_t cmdByte,
  output logic [3:0] bitCount
);
  fwpg_pkg::fwpg_byte_t shift_ff;
  fwpg_pkg::fwpg_byte_t nxt_shift;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic first_ff;

  always_comb begin
    nxt_shift = shift_ff;
    nxt_cnt = cnt_ff;
    if (first_ff) begin
      // first edge of a frame starts afresh; until then the last frame stays readable
      nxt_shift = {7'h00, serialInLine};
      nxt_cnt = 4'h1;
    end else begin
      if (cnt_ff < `FWPG_CMD_BITS) begin
        nxt_shift = {shift_ff[6:0], serialInLine};
      end
      // saturating count lets the core spot edges beyond the opcode
      if (cnt_ff != `FWPG_BITCNT_SAT) begin
        nxt_cnt = cnt_ff + 4'h1;
      end
    end
  end

  // select high only arms the restart, so byte and count survive for the clk side
  always_ff @(posedge serialClk or posedge chipSelN) begin
    if (chipSelN) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  // no reset: written only by link clock edges inside a frame
  always_ff @(posedge serialClk) begin
    shift_ff <= nxt_shift;
    cnt_ff <= nxt_cnt;
  end

  assign cmdByte = shift_ff;
  assign bitCount = cnt_ff;
endmodule // fwpg_link

// ==== verilog/fwpg_top.sv ====
// deep power-down wake and power-up command gate of a serial flash
// Summary of operation
// - in deep power-down only the wake command is obeyed; it leaves that mode
// - wake ends at select rise; extra clock edges reject it
// - after a valid wake and the wake delay, enter standby and await commands
// - wake during a busy erase, program or write cycle is rejected, cycle untouched
// - below inhibit threshold logic is held in reset and answers nothing
// - write-class commands ignored until the power-up write delay elapses
// - reads accepted once the select delay after supply has passed
// - power-up ends in standby with write latch and busy flags cleared
// - supply falling below inhibit threshold stops all operation
// - wake delay from select rise to standby is at most the wake time
// - only the power-down command enters deep mode; writes ignored there
`timescale 1ns/100ps
`include "fwpg_params.svh"
module fwpg_top #(
  parameter int PUW_CYC = `FWPG_PUW_CYC,
  parameter logic [7:0] OP_DEEP = 8'hb9,
  parameter logic [7:0] OP_WAKE = 8'hab,
  parameter logic [7:0] OP_WREN = 8'h06,
  parameter logic [7:0] OP_PW = 8'h0a,
  parameter logic [7:0] OP_PP = 8'h02,
  parameter logic [7:0] OP_PE = 8'hdb,
  parameter logic [7:0] OP_SE = 8'hd8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic powerGood,
  input wire logic busyCycle,
  input wire logic serialClk,
  input wire logic chipSelN,
  input wire logic serialInLine,
  output logic deepPowerDown,
  output logic standbyMode,
  output logic cmdGo,
  output fwpg_pkg::fwpg_byte_t cmdCode,
  output logic writeAllowed,
  output logic readAllowed,
  output logic flagClear
);
  localparam int VSL_CYC = `FWPG_VSL_CYC;
  localparam int WAKE_CYC = `FWPG_WAKE_CYC;
  localparam int PW = $clog2(PUW_CYC + 1);
  localparam int VW = $clog2(VSL_CYC + 1);
  localparam int WW = $clog2(WAKE_CYC + 1);
  // select sync costs up to three clk edges, so the wake count ends that much early
  localparam int WAKE_END = WAKE_CYC - 4;

  generate
    if (PUW_CYC < 1) begin : g_bad_puw
      $error("PUW_CYC must be at least one cycle");
    end
    if (WAKE_CYC < 5 || VSL_CYC < 1) begin : g_bad_timing
      $error("wake and select delays too short for the synchroniser");
    end
  endgenerate

  fwpg_pkg::fwpg_byte_t linkByte;
  logic [3:0] linkBits;

  // limitation: a select with no clock edges shows the previous frame's byte again
  fwpg_link u_link (
    .serialClk(serialClk),
    .chipSelN(chipSelN),
    .serialInLine(serialInLine),
    .cmdByte(linkByte),
    .bitCount(linkBits)
  );

  // select synchroniser; byte and count are static once select is high
  logic csMeta_ff;
  logic csSync_ff;
  logic csPrev_ff;
  fwpg_pkg::fwpg_state_e state_ff;
  fwpg_pkg::fwpg_state_e nxt_state;
  logic [PW-1:0] puwCnt_ff;
  logic [PW-1:0] nxt_puwCnt;
  logic [VW-1:0] vslCnt_ff;
  logic [VW-1:0] nxt_vslCnt;
  logic [WW-1:0] wakeCnt_ff;
  logic [WW-1:0] nxt_wakeCnt;
  logic deep_ff;
  logic standby_ff;
  logic go_ff;
  fwpg_pkg::fwpg_byte_t code_ff;
  logic wrOk_ff;
  logic rdOk_ff;
  logic clr_ff;
  logic nxt_deep;
  logic nxt_standby;
  logic nxt_go;
  fwpg_pkg::fwpg_byte_t nxt_code;
  logic nxt_wrOk;
  logic nxt_rdOk;
  logic nxt_clr;
  logic csRise;
  logic exactByte;
  logic isWrite;
  logic puwDone;
  logic vslDone;

  always_comb begin
    csRise = csSync_ff & ~csPrev_ff;
    exactByte = (linkBits == `FWPG_CMD_BITS);
    isWrite = (linkByte == OP_WREN) || (linkByte == OP_PW) || (linkByte == OP_PP) ||
              (linkByte == OP_PE) || (linkByte == OP_SE);
    puwDone = (puwCnt_ff == PW'(PUW_CYC));
    vslDone = (vslCnt_ff == VW'(VSL_CYC));
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_puwCnt = puwCnt_ff;
    nxt_vslCnt = vslCnt_ff;
    nxt_wakeCnt = wakeCnt_ff;
    nxt_go = 1'b0;
    nxt_code = code_ff;
    if (!puwDone) begin
      nxt_puwCnt = puwCnt_ff + PW'(1);
    end
    if (!vslDone) begin
      nxt_vslCnt = vslCnt_ff + VW'(1);
    end
    case (state_ff)
      fwpg_pkg::ST_OFF: begin
        nxt_puwCnt = '0;
        nxt_vslCnt = '0;
        if (powerGood) begin
          nxt_state = fwpg_pkg::ST_STANDBY;
        end
      end
      fwpg_pkg::ST_STANDBY: begin
        if (csRise) begin
          if (linkByte == OP_DEEP) begin
            if (exactByte && !busyCycle) begin
              nxt_state = fwpg_pkg::ST_DEEP;
            end
          end else if (isWrite) begin
            nxt_go = puwDone && vslDone;
          end else begin
            nxt_go = vslDone;
          end
        end
      end
      fwpg_pkg::ST_DEEP: begin
        // a wake during a busy cycle is dropped; everything else is ignored here
        if (csRise && linkByte == OP_WAKE && exactByte && !busyCycle) begin
          nxt_state = fwpg_pkg::ST_WAKING;
          nxt_wakeCnt = '0;
        end
      end
      fwpg_pkg::ST_WAKING: begin
        // selects during this time are host errors and are ignored
        nxt_wakeCnt = wakeCnt_ff + WW'(1);
        if (wakeCnt_ff == WW'(WAKE_END)) begin
          nxt_state = fwpg_pkg::ST_STANDBY;
        end
      end
      default: nxt_state = fwpg_pkg::ST_OFF;
    endcase
    if (!powerGood) begin
      nxt_state = fwpg_pkg::ST_OFF;
      nxt_go = 1'b0;
    end
    // the opcode moves only with an accepted command, so refused frames leave no trace
    if (nxt_go) begin
      nxt_code = linkByte;
    end
    nxt_clr = (nxt_state == fwpg_pkg::ST_OFF);
    nxt_deep = (nxt_state == fwpg_pkg::ST_DEEP) || (nxt_state == fwpg_pkg::ST_WAKING);
    nxt_standby = (nxt_state == fwpg_pkg::ST_STANDBY);
    nxt_wrOk = nxt_standby && (nxt_puwCnt == PW'(PUW_CYC)) &&
               (nxt_vslCnt == VW'(VSL_CYC));
    nxt_rdOk = nxt_standby && (nxt_vslCnt == VW'(VSL_CYC));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      csMeta_ff <= 1'b1;
      csSync_ff <= 1'b1;
      csPrev_ff <= 1'b1;
      state_ff <= fwpg_pkg::ST_OFF;
      puwCnt_ff <= '0;
      vslCnt_ff <= '0;
      wakeCnt_ff <= '0;
      deep_ff <= 1'b0;
      standby_ff <= 1'b0;
      go_ff <= 1'b0;
      code_ff <= 8'h00;
      wrOk_ff <= 1'b0;
      rdOk_ff <= 1'b0;
      clr_ff <= 1'b1;
    end else begin
      csMeta_ff <= chipSelN;
      csSync_ff <= csMeta_ff;
      csPrev_ff <= csSync_ff;
      state_ff <= nxt_state;
      puwCnt_ff <= nxt_puwCnt;
      vslCnt_ff <= nxt_vslCnt;
      wakeCnt_ff <= nxt_wakeCnt;
      deep_ff <= nxt_deep;
      standby_ff <= nxt_standby;
      go_ff <= nxt_go;
      code_ff <= nxt_code;
      wrOk_ff <= nxt_wrOk;
      rdOk_ff <= nxt_rdOk;
      clr_ff <= nxt_clr;
    end
  end

  assign deepPowerDown = deep_ff;
  assign standbyMode = standby_ff;
  assign cmdGo = go_ff;
  assign cmdCode = code_ff;
  assign writeAllowed = wrOk_ff;
  assign readAllowed = rdOk_ff;
  assign flagClear = clr_ff;
endmodule // fwpg_top

// ==== dv/fwpg_checker_assertions.sv ====
// concurrent checks on the ports of the wake and power-up gate
`timescale 1ns/100ps
module fwpg_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic powerGood,
  input wire logic deepPowerDown,
  input wire logic standbyMode,
  input wire logic cmdGo,
  input fwpg_pkg::fwpg_byte_t cmdCode,
  input wire logic writeAllowed,
  input wire logic readAllowed,
  input wire logic flagClear
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_off_quiet: assert property (!powerGood |=> flagClear && !standbyMode && !readAllowed)
    else $error("outputs not quiet while unpowered");
  a_off_no_go: assert property (!powerGood |=> !cmdGo)
    else $error("command taken while unpowered");
  a_write_gate: assert property (cmdGo && cmdCode inside {8'h06, 8'h0a, 8'h02, 8'hdb, 8'hd8}
    |-> writeAllowed)
    else $error("write command taken too early");
  a_read_gate: assert property (cmdGo && cmdCode == 8'h03 |-> readAllowed)
    else $error("read taken before select delay");
  a_write_needs_rd: assert property (writeAllowed |-> readAllowed)
    else $error("write window open without read window");
  a_pwr_standby: assert property (flagClear && powerGood |=> standbyMode && !flagClear)
    else $error("power-up did not reach standby");
  a_wake_ends: assert property ($fell(deepPowerDown) && $past(powerGood) |-> standbyMode)
    else $error("left deep mode without standby");
  a_deep_no_go: assert property (deepPowerDown && $past(deepPowerDown) |-> !cmdGo)
    else $error("command taken in deep mode");
  a_code_only_go: assert property ($changed(cmdCode) |-> cmdGo)
    else $error("opcode changed without a pulse");
  cover property ($fell(deepPowerDown));
  cover property (cmdGo && writeAllowed);
  cover property ($rose(readAllowed));
endmodule // fwpg_checker
bind fwpg_top fwpg_checker chk_u (.clk, .rst, .powerGood, .deepPowerDown, .standbyMode, .cmdGo,
  .cmdCode, .writeAllowed, .readAllowed, .flagClear);

// ==== dv/fwpg_host.sv ====
// host-side model that frames one command on the serial link
`timescale 1ns/100ps
module fwpg_host (
  output logic serialClk,
  output logic chipSelN,
  output logic serialInLine
);
  initial begin
    serialClk = 1'h0;
    serialInLine = 1'h0;
    // rising just after time zero gives the link its first restart edge
    #1 chipSelN = 1'h1; // deselected until the bench frames
  end
  // link clock only runs inside a frame; a stopped clock keeps the handover quiet
  task automatic send(input logic [7:0] op, input int n);
    chipSelN = 1'h0; // held low for the whole frame
    for (int i = 0; i < n; i++) begin
      serialInLine = op[7 - (i % 8)];
      #7.5 serialClk = 1'h1;
      #7.5 serialClk = 1'h0;
    end
    #7.5 chipSelN = 1'h1;
    serialInLine = ~serialInLine; // released line must not look like the last bit
  endtask
endmodule // fwpg_host

// ==== dv/fwpg_top_tb.sv ====
// self-checking bench for the wake and power-up gate
`timescale 1ns/100ps
module fwpg_top_tb;
  logic clk = 1'h0, rst = 1'h1, powerGood = 1'h1, busyCycle = 1'h0;
  logic serialClk, chipSelN, serialInLine, deepPowerDown, standbyMode, cmdGo;
  logic writeAllowed, readAllowed, flagClear;
  fwpg_pkg::fwpg_byte_t cmdCode;
  int n_mismatch = 0, n_compared = 0;
  // top bit: taken before the write delay ends
  logic [8:0] rows [6] = '{9'h006, 9'h00a, 9'h002, 9'h0db, 9'h0d8, 9'h103};
  always #10 clk = ~clk;
  fwpg_top #(.PUW_CYC(2000)) dut_u (.clk, .rst, .powerGood, .busyCycle, .serialClk, .chipSelN,
    .serialInLine, .deepPowerDown, .standbyMode, .cmdGo, .cmdCode, .writeAllowed,
    .readAllowed, .flagClear);
  fwpg_host host_u (.serialClk, .chipSelN, .serialInLine);
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic frame(input logic [7:0] op, input int n, output logic seen);
    seen = 1'h0;
    @(negedge clk) #3 host_u.send(op, n);
    repeat (10) @(negedge clk) seen |= cmdGo;
  endtask
  task automatic wait_std(output int k);
    for (k = 0; k < 1600 && standbyMode !== 1'h1; k++) @(negedge clk);
    if (k == 1600) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  initial begin
    logic g;
    int k;
    repeat (4) @(negedge clk); // reset held through power-up
    chk({deepPowerDown, standbyMode, cmdGo, writeAllowed, readAllowed, flagClear}, 6'h01);
    rst = 1'h0;
    wait_std(k);
    chk({deepPowerDown, flagClear}, 2'h0);
    repeat (1510) @(negedge clk);
    chk({readAllowed, writeAllowed}, 2'h2);
    for (int p = 0; p < 2; p++) begin
      foreach (rows[i]) begin
        frame(rows[i][7:0], 8, g);
        chk(g, rows[i][8] | p[0]);
        if (g === 1'h1) chk(cmdCode, rows[i][7:0]);
      end
      repeat (500) @(negedge clk); // writes resent only after both delays
    end
    frame(8'hb9, 8, g);
    chk(deepPowerDown, 1'h1);
    frame(8'h03, 8, g);
    chk({g, deepPowerDown}, 2'h1);
    busyCycle = 1'h1;
    frame(8'hab, 8, g);
    busyCycle = 1'h0;
    frame(8'hab, 9, g);
    repeat (1600) @(negedge clk);
    chk({deepPowerDown, standbyMode}, 2'h2);
    frame(8'hab, 8, g);
    chk({deepPowerDown, standbyMode}, 2'h2);
    wait_std(k); // select kept high through the wake delay
    // 1491 negedges after the frame returns is the first sample after the last clk edge within 30 us of select rise
    chk(k > 1400 && k <= 1491, 1'h1);
    powerGood = 1'h0;
    frame(8'h03, 8, g);
    chk({g, standbyMode, readAllowed, flagClear}, 4'h1);
    powerGood = 1'h1;
    wait_std(k);
    chk({deepPowerDown, flagClear, writeAllowed}, 3'h0);
    rst = 1'h1;
    repeat (2) @(negedge clk);
    chk({standbyMode, readAllowed, flagClear}, 3'h1);
    rst = 1'h0;
    wait_std(k);
    chk({deepPowerDown, readAllowed, flagClear}, 3'h0);
    wrap_up();
  end
  initial begin
    #1_500_000;
    n_mismatch++;
    wrap_up();
  end
endmodule // fwpg_top_tb
